// file: rtl/pedt_pkg.sv
package pedt_pkg;

    // apb geometry
    localparam int PEDT_ADDR_W = 12;                 // byte address width
    localparam int PEDT_DATA_W = 32;                 // apb data width
    localparam int PEDT_STRB_W = 4;                  // byte lanes

    // printed register indices, byte address is four times the index
    localparam logic [7:0] PEDT_IDX_PAIR_C = 8'h6E; // trim pair c (edges eleven, twelve)
    localparam logic [7:0] PEDT_IDX_PAIR_D = 8'h6F; // trim pair d (edges thirteen, fourteen)
    localparam logic [7:0] PEDT_IDX_STATUS = 8'h70; // applied settings and flags

    // trim register layout
    localparam int PEDT_TRIM_W      = 8;             // width of a trim register
    localparam int PEDT_CODE_W      = 3;             // width of an offset code
    localparam int PEDT_POL_HI_BIT  = 7;             // polarity, upper edge
    localparam int PEDT_CODE_HI_LSB = 4;             // code [6:4], upper edge
    localparam int PEDT_POL_LO_BIT  = 3;             // polarity, lower edge
    localparam int PEDT_CODE_LO_LSB = 0;             // code [2:0], lower edge
    localparam logic [PEDT_TRIM_W-1:0] PEDT_TRIM_RESET = 8'h00;

    // status register layout
    localparam int PEDT_ST_APPLIED_C_LSB = 0;        // applied pair c copy
    localparam int PEDT_ST_APPLIED_D_LSB = 8;        // applied pair d copy
    localparam int PEDT_ST_PENDING_BIT   = 16;       // new value waits for period start
    localparam int PEDT_ST_CLAMP_LSB     = 20;       // sticky clamp flags, one per edge
    localparam int PEDT_ST_CLAMP_LANE    = 2;        // byte lane holding clamp flags

    // edge timing, positions counted in fine ticks
    localparam int PEDT_NUM_EDGES   = 4;             // edges eleven to fourteen
    localparam int PEDT_NOM_W       = 12;            // width of an edge position
    localparam int PEDT_TRIM_STEP_NS = 5;            // displacement per code step
    localparam int PEDT_FINE_TICK_NS = 5;            // resolution of an edge position
    localparam int PEDT_STEP_TICKS  =
        (PEDT_TRIM_STEP_NS + PEDT_FINE_TICK_NS - 1) / PEDT_FINE_TICK_NS;

    // trim application state
    typedef enum logic [0:0] {
        PEDT_SYNCED  = 1'b0,                         // applied equals written
        PEDT_PENDING = 1'b1                          // written waits for period start
    } pedt_state_t;

    // byte address of a register index
    function automatic logic [PEDT_ADDR_W-1:0] pedt_byte_addr(input logic [7:0] idx);
        pedt_byte_addr = {2'h0, idx, 2'h0};
    endfunction

    // offset code of the upper or lower half of a trim register
    function automatic logic [PEDT_CODE_W-1:0] pedt_code(input logic [PEDT_TRIM_W-1:0] r,
                                                           input logic upper);
        pedt_code = upper ? r[PEDT_CODE_HI_LSB +: PEDT_CODE_W]
                          : r[PEDT_CODE_LO_LSB +: PEDT_CODE_W];
    endfunction

    // polarity of the upper or lower half, one means negative shift
    function automatic logic pedt_pol(input logic [PEDT_TRIM_W-1:0] r, input logic upper);
        pedt_pol = upper ? r[PEDT_POL_HI_BIT] : r[PEDT_POL_LO_BIT];
    endfunction

endpackage

// file: rtl/pedt_rst_sync.sv
`timescale 1ns/1ps
module pedt_rst_sync (
    input  wire logic clk_in,      // block clock
    input  wire logic rst_b_in,    // async reset, active low
    output logic      rst_b_out    // released copy, active low
);
    logic meta_r;                  // first stage, read only by second

    // assert at once, release after two edges
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r    <= 1'b0;
            rst_b_out <= 1'b0;
        end else begin
            meta_r    <= 1'b1;
            rst_b_out <= meta_r;
        end
    end
endmodule

// file: rtl/pedt_edge_adj.sv
`timescale 1ns/1ps
module pedt_edge_adj
    import pedt_pkg::*;
(
    input  wire logic                   clk_in,      // block clock
    input  wire logic                   rst_b_in,    // synced reset, active low
    input  wire logic [PEDT_NOM_W-1:0]  nominal_in,  // nominal position, fine ticks
    input  wire logic [PEDT_CODE_W-1:0] code_in,     // applied offset code
    input  wire logic                   neg_in,      // one shifts earlier
    output logic      [PEDT_NOM_W-1:0]  pos_out,     // trimmed position
    output logic                        clamp_out    // result hit a range limit
);
    localparam logic [PEDT_NOM_W:0] STEP = (PEDT_NOM_W+1)'(PEDT_STEP_TICKS);
    localparam logic [PEDT_NOM_W-1:0] POS_MAX = '1;

    wire logic [PEDT_NOM_W:0]   code_ext;   // widened code
    wire logic [PEDT_NOM_W:0]   disp;       // displacement in ticks
    wire logic [PEDT_NOM_W:0]   sum;        // positive shift with carry
    wire logic [PEDT_NOM_W:0]   diff;       // negative shift with borrow
    wire logic [PEDT_NOM_W-1:0] pos_nxt;    // clamped result
    wire logic                  clamp_nxt;  // limit reached

    assign code_ext  = {{(PEDT_NOM_W+1-PEDT_CODE_W){1'b0}}, code_in};
    assign disp      = code_ext * STEP;
    assign sum       = {1'b0, nominal_in} + disp;
    assign diff      = {1'b0, nominal_in} - disp;
    // polarity picks direction, saturate instead of wrapping
    assign pos_nxt   = neg_in ? (diff[PEDT_NOM_W] ? '0 : diff[PEDT_NOM_W-1:0])
                              : (sum[PEDT_NOM_W] ? POS_MAX : sum[PEDT_NOM_W-1:0]);
    assign clamp_nxt = neg_in ? diff[PEDT_NOM_W] : sum[PEDT_NOM_W];

    // register the trimmed edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pos_out   <= '0;
            clamp_out <= 1'b0;
        end else begin
            pos_out   <= pos_nxt;
            clamp_out <= clamp_nxt;
        end
    end
endmodule

// file: rtl/pedt_top.sv
// Operation
// - polarity zero shifts later, one earlier
// - edge eleven offset from pair c [6:4]
// - edge twelve offset from pair c [2:0]
// - edge thirteen offset from pair d [6:4]
// - edge fourteen offset from pair d [2:0]
`timescale 1ns/1ps
module pedt_top
    import pedt_pkg::*;
(
    input  wire logic                   clk_in,                  // 25 mhz block clock
    input  wire logic                   rst_b_in,                // async reset, active low
    // apb slave
    input  wire logic                   psel_in,                 // slave select
    input  wire logic                   penable_in,              // access phase
    input  wire logic                   pwrite_in,               // one for write
    input  wire logic [PEDT_ADDR_W-1:0] paddr_in,                // byte address
    input  wire logic [PEDT_DATA_W-1:0] pwdata_in,               // write data
    input  wire logic [PEDT_STRB_W-1:0] pstrb_in,                // write byte lanes
    output logic      [PEDT_DATA_W-1:0] prdata_out,              // read data
    output logic                        pready_out,              // transfer done
    output logic                        pslverr_out,             // unmapped access
    // waveform generator side
    input  wire logic                   period_start_in,         // first cycle of period
    input  wire logic [PEDT_NOM_W-1:0]  edge_eleven_nom_in,      // nominal positions
    input  wire logic [PEDT_NOM_W-1:0]  edge_twelve_nom_in,
    input  wire logic [PEDT_NOM_W-1:0]  edge_thirteen_nom_in,
    input  wire logic [PEDT_NOM_W-1:0]  edge_fourteen_nom_in,
    output logic      [PEDT_NOM_W-1:0]  edge_eleven_pos_out,     // trimmed positions
    output logic      [PEDT_NOM_W-1:0]  edge_twelve_pos_out,
    output logic      [PEDT_NOM_W-1:0]  edge_thirteen_pos_out,
    output logic      [PEDT_NOM_W-1:0]  edge_fourteen_pos_out,
    output logic                        trim_pending_out         // written, not yet applied
);

    localparam logic [PEDT_ADDR_W-1:0] ADDR_PAIR_C = pedt_byte_addr(PEDT_IDX_PAIR_C);
    localparam logic [PEDT_ADDR_W-1:0] ADDR_PAIR_D = pedt_byte_addr(PEDT_IDX_PAIR_D);
    localparam logic [PEDT_ADDR_W-1:0] ADDR_STATUS = pedt_byte_addr(PEDT_IDX_STATUS);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    wire logic rst_b;                                    // synced reset, active low

    pedt_rst_sync u_rst_sync (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .rst_b_out (rst_b)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [PEDT_TRIM_W-1:0]    trim_c_r;                 // written pair c
    logic [PEDT_TRIM_W-1:0]    trim_d_r;                 // written pair d
    logic [PEDT_TRIM_W-1:0]    applied_c_r;              // pair c in use this period
    logic [PEDT_TRIM_W-1:0]    applied_d_r;              // pair d in use this period
    pedt_state_t               state_r;                  // application state
    pedt_state_t               state_nxt;
    logic [PEDT_NUM_EDGES-1:0] clamp_seen_r;             // sticky clamp flags
    logic [PEDT_NUM_EDGES-1:0] clamp_seen_nxt;
    logic                      pready_r;                 // access phase ready
    logic                      pslverr_r;                // error for current transfer
    logic [PEDT_DATA_W-1:0]    prdata_r;                 // read data for current transfer
    logic                      pending_r;                // mirror of pending state

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire logic                      setup;               // setup phase of a transfer
    wire logic                      complete;            // access edge that ends it
    wire logic                      hit_c;               // address selects pair c
    wire logic                      hit_d;               // address selects pair d
    wire logic                      hit_st;              // address selects status
    wire logic                      mapped;              // any register selected
    wire logic                      bad_access;          // unmapped address selected
    wire logic                      wr_c;                // write lands in pair c
    wire logic                      wr_d;                // write lands in pair d
    wire logic                      wr_clr;              // clear strobe for clamp flags
    wire logic                      trim_written;        // either pair written
    wire logic [PEDT_NUM_EDGES-1:0] clamp_clr;           // flags to clear
    wire logic [PEDT_DATA_W-1:0]    status_word;         // status read value
    wire logic [PEDT_DATA_W-1:0]    rd_word;             // selected read value

    assign setup    = psel_in & ~penable_in;
    assign complete = psel_in & penable_in & pready_r;
    assign hit_c    = (paddr_in == ADDR_PAIR_C);
    assign hit_d    = (paddr_in == ADDR_PAIR_D);
    assign hit_st   = (paddr_in == ADDR_STATUS);
    assign mapped   = hit_c | hit_d | hit_st;
    // unmapped addresses answer with an error, writes to them vanish
    assign bad_access = ~mapped;

    // writes take effect only at the completing edge, trim pairs on byte lane zero, clamp clear on lane two
    assign wr_c   = complete & pwrite_in & hit_c & pstrb_in[0];
    assign wr_d   = complete & pwrite_in & hit_d & pstrb_in[0];
    assign wr_clr = complete & pwrite_in & hit_st & pstrb_in[PEDT_ST_CLAMP_LANE];
    assign trim_written = wr_c | wr_d;
    assign clamp_clr = wr_clr ? pwdata_in[PEDT_ST_CLAMP_LSB +: PEDT_NUM_EDGES] : '0;

    // status word: applied copies, pending flag, sticky clamp flags
    assign status_word = (PEDT_DATA_W'(applied_c_r) << PEDT_ST_APPLIED_C_LSB)
                       | (PEDT_DATA_W'(applied_d_r) << PEDT_ST_APPLIED_D_LSB)
                       | (PEDT_DATA_W'(pending_r) << PEDT_ST_PENDING_BIT)
                       | (PEDT_DATA_W'(clamp_seen_r) << PEDT_ST_CLAMP_LSB);

    // read mux, narrow registers sit in the low bits
    assign rd_word = hit_c  ? PEDT_DATA_W'(trim_c_r) :
                     hit_d  ? PEDT_DATA_W'(trim_d_r) :
                     hit_st ? status_word            : '0;

    // apb answer: ready in the first access cycle, data captured at setup
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else if (setup) begin
            pready_r  <= 1'b1;
            pslverr_r <= bad_access;
            prdata_r  <= pwrite_in ? '0 : rd_word;
        end else if (complete || !psel_in) begin
            // transfer over, drop ready and error
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // written trim registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            trim_c_r <= PEDT_TRIM_RESET;
            trim_d_r <= PEDT_TRIM_RESET;
        end else begin
            if (wr_c) begin
                trim_c_r <= pwdata_in[PEDT_TRIM_W-1:0];
            end
            if (wr_d) begin
                trim_d_r <= pwdata_in[PEDT_TRIM_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // application of new settings
    // ------------------------------------------------------------------
    // pending until period
    // a write in the start cycle keeps pending, so it waits one more period
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PEDT_SYNCED: begin
                if (trim_written) begin
                    state_nxt = PEDT_PENDING;
                end
            end
            PEDT_PENDING: begin
                if (!trim_written && period_start_in) begin
                    state_nxt = PEDT_SYNCED;
                end
            end
        endcase
    end

    // state and its output copy
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= PEDT_SYNCED;
            pending_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            pending_r <= (state_nxt == PEDT_PENDING);
        end
    end

    // load at start
    // applied copies change only on the first cycle of a period
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            applied_c_r <= PEDT_TRIM_RESET;
            applied_d_r <= PEDT_TRIM_RESET;
        end else if (period_start_in) begin
            applied_c_r <= trim_c_r;
            applied_d_r <= trim_d_r;
        end
    end

    // ------------------------------------------------------------------
    // per edge trimming
    // ------------------------------------------------------------------
    logic [PEDT_NOM_W-1:0]     nom_w [PEDT_NUM_EDGES];   // nominal per edge
    logic [PEDT_NOM_W-1:0]     pos_w [PEDT_NUM_EDGES];   // trimmed per edge
    logic [PEDT_CODE_W-1:0]    code_w [PEDT_NUM_EDGES];  // applied code per edge
    logic [PEDT_NUM_EDGES-1:0] neg_w;                    // applied polarity per edge
    logic [PEDT_NUM_EDGES-1:0] clamp_w;                  // clamp per edge

    assign nom_w[0] = edge_eleven_nom_in;
    assign nom_w[1] = edge_twelve_nom_in;
    assign nom_w[2] = edge_thirteen_nom_in;
    assign nom_w[3] = edge_fourteen_nom_in;

    assign code_w[0] = pedt_code(applied_c_r, 1'b1);
    assign code_w[1] = pedt_code(applied_c_r, 1'b0);
    assign code_w[2] = pedt_code(applied_d_r, 1'b1);
    assign code_w[3] = pedt_code(applied_d_r, 1'b0);

    assign neg_w = {pedt_pol(applied_d_r, 1'b0), pedt_pol(applied_d_r, 1'b1),
                    pedt_pol(applied_c_r, 1'b0), pedt_pol(applied_c_r, 1'b1)};

    // one adder per edge, code times step ticks
    for (genvar e = 0; e < PEDT_NUM_EDGES; e++) begin : g_edge
        pedt_edge_adj u_adj (
            .clk_in     (clk_in),
            .rst_b_in   (rst_b),
            .nominal_in (nom_w[e]),
            .code_in    (code_w[e]),
            .neg_in     (neg_w[e]),
            .pos_out    (pos_w[e]),
            .clamp_out  (clamp_w[e])
        );
    end

    // sticky clamp flags, a new clamp wins over a clear in the same cycle
    assign clamp_seen_nxt = clamp_w | (clamp_seen_r & ~clamp_clr);

    // clamp flag register
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            clamp_seen_r <= '0;
        end else begin
            clamp_seen_r <= clamp_seen_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign prdata_out            = prdata_r;
    assign pready_out            = pready_r;
    assign pslverr_out           = pslverr_r;
    assign trim_pending_out      = pending_r;
    assign edge_eleven_pos_out   = pos_w[0];
    assign edge_twelve_pos_out   = pos_w[1];
    assign edge_thirteen_pos_out = pos_w[2];
    assign edge_fourteen_pos_out = pos_w[3];

endmodule

// file: dv/pedt_top_sva.sv
`timescale 1ns/1ps
module pedt_top_sva
    import pedt_pkg::*;
(
    input wire logic                   clk_in,
    input wire logic                   rst_b_in,
    input wire logic                   psel_in,
    input wire logic                   penable_in,
    input wire logic                   pwrite_in,
    input wire logic [PEDT_ADDR_W-1:0] paddr_in,
    input wire logic [PEDT_STRB_W-1:0] pstrb_in,
    input wire logic                   pready_out,
    input wire logic                   pslverr_out,
    input wire logic                   period_start_in,
    input wire logic [PEDT_NOM_W-1:0]  edge_eleven_nom_in,
    input wire logic [PEDT_NOM_W-1:0]  edge_twelve_nom_in,
    input wire logic [PEDT_NOM_W-1:0]  edge_thirteen_nom_in,
    input wire logic [PEDT_NOM_W-1:0]  edge_fourteen_nom_in,
    input wire logic [PEDT_NOM_W-1:0]  edge_eleven_pos_out,
    input wire logic [PEDT_NOM_W-1:0]  edge_twelve_pos_out,
    input wire logic [PEDT_NOM_W-1:0]  edge_thirteen_pos_out,
    input wire logic [PEDT_NOM_W-1:0]  edge_fourteen_pos_out,
    input wire logic                   trim_pending_out
);
    logic [2:0] up_r;                             // edges since reset release
    wire        live = (up_r == 3'h4);            // synchroniser settled
    wire        hit  = (paddr_in == 12'h1B8) || (paddr_in == 12'h1BC);
    wire        wr_trim = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0] && hit;

    // count out the reset synchroniser
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            up_r <= 3'h0;
        end else if (!live) begin
            up_r <= up_r + 3'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in || !live);

    // apb setup then one ready cycle
    sequence s_setup; psel_in && !penable_in; endsequence
    sequence s_answer; pready_out ##1 !pready_out; endsequence
    property p_apb_answer; s_setup |=> s_answer; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("ready not single cycle");
    property p_err_ready; pslverr_out |-> pready_out; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_pend_set; wr_trim && !period_start_in |=> trim_pending_out; endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set");
    property p_pend_clear; period_start_in && !wr_trim |=> !trim_pending_out; endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");
    property p_pend_cause; $rose(trim_pending_out) |-> $past(wr_trim); endproperty
    a_pend_cause: assert property (p_pend_cause) else $error("pending without write");

    // positions move only with nominal or period start
    property p_hold_eleven;
        $stable(edge_eleven_nom_in) && !$past(period_start_in) |=> $stable(edge_eleven_pos_out);
    endproperty
    a_hold_eleven: assert property (p_hold_eleven) else $error("edge eleven moved");
    property p_hold_twelve;
        $stable(edge_twelve_nom_in) && !$past(period_start_in) |=> $stable(edge_twelve_pos_out);
    endproperty
    a_hold_twelve: assert property (p_hold_twelve) else $error("edge twelve moved");
    property p_hold_thirteen;
        $stable(edge_thirteen_nom_in) && !$past(period_start_in) |=>
            $stable(edge_thirteen_pos_out);
    endproperty
    a_hold_thirteen: assert property (p_hold_thirteen) else $error("edge 13 moved");
    property p_hold_fourteen;
        $stable(edge_fourteen_nom_in) && !$past(period_start_in) |=>
            $stable(edge_fourteen_pos_out);
    endproperty
    a_hold_fourteen: assert property (p_hold_fourteen) else $error("edge 14 moved");
endmodule

bind pedt_top pedt_top_sva i_sva (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pstrb_in, .pready_out, .pslverr_out, .period_start_in, .edge_eleven_nom_in,
    .edge_twelve_nom_in, .edge_thirteen_nom_in, .edge_fourteen_nom_in, .edge_eleven_pos_out,
    .edge_twelve_pos_out, .edge_thirteen_pos_out, .edge_fourteen_pos_out, .trim_pending_out);

// file: dv/test_pwm_edge_delay_trim.sv
`timescale 1ns/1ps
module test_pwm_edge_delay_trim
    import pedt_pkg::*;
;
    localparam logic [11:0] ADDR_C = 12'h1B8;     // trim pair c
    localparam logic [11:0] ADDR_D = 12'h1BC;     // trim pair d
    localparam logic [11:0] ADDR_S = 12'h1C0;     // status
    localparam logic [11:0] ADDR_X = 12'h1C4;     // unmapped
    logic                   clk_in;
    logic                   rst_b_in;
    logic                   psel_in;
    logic                   penable_in;
    logic                   pwrite_in;
    logic [PEDT_ADDR_W-1:0] paddr_in;
    logic [PEDT_DATA_W-1:0] pwdata_in;
    logic [PEDT_STRB_W-1:0] pstrb_in;
    logic [PEDT_DATA_W-1:0] prdata_out;
    logic                   pready_out;
    logic                   pslverr_out;
    logic                   period_start_in;
    logic                   trim_pending_out;
    logic [PEDT_NOM_W-1:0]  nom [4];             // nominal positions
    logic [PEDT_NOM_W-1:0]  pos [4];             // trimmed positions
    logic [7:0]             tc;                  // applied pair c
    logic [7:0]             td;                  // applied pair d
    logic [7:0]             nc;                  // next pair c
    logic [7:0]             nd;                  // next pair d
    int                     fails;
    int                     checks;

    pedt_top i_dut (
        .clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .period_start_in,
        .edge_eleven_nom_in(nom[0]), .edge_twelve_nom_in(nom[1]),
        .edge_thirteen_nom_in(nom[2]), .edge_fourteen_nom_in(nom[3]),
        .edge_eleven_pos_out(pos[0]), .edge_twelve_pos_out(pos[1]),
        .edge_thirteen_pos_out(pos[2]), .edge_fourteen_pos_out(pos[3]), .trim_pending_out);

    // clock, half period 20 ns
    always #20 clk_in = ~clk_in;

    // count and report one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask

    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        pstrb_in   <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // wait for ready, only the watchdog ends a hang
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        chk({31'h0, pready_out}, 32'h1, "apb ready");
        r = prdata_out;
        e = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, s, r, x);
        chk({31'h0, x}, {31'h0, e}, "write error flag");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0, 4'h0, r, x);
        chk(r, d, "read data");
        chk({31'h0, x}, {31'h0, e}, "read error flag");
    endtask

    // one cycle period start pulse
    task automatic start_period;
        @(posedge clk_in);
        period_start_in <= 1'b1;
        @(posedge clk_in);
        period_start_in <= 1'b0;
    endtask

    // position from nominal, code in 5 ns ticks, polarity one is earlier
    function automatic logic [11:0] trimmed(input logic [11:0] n, input logic [7:0] t,
                                            input logic up);
        int v;
        v = (up ? int'(t[6:4]) : int'(t[2:0])) * PEDT_STEP_TICKS;
        v = (up ? t[7] : t[3]) ? int'(n) - v : int'(n) + v;
        v = (v < 0) ? 0 : ((v > 4095) ? 4095 : v);
        return v[11:0];
    endfunction

    // status word with pending low
    function automatic logic [31:0] stat(input logic [7:0] c, input logic [7:0] d,
                                         input logic [3:0] k);
        return {8'h00, k, 4'h0, d, c};
    endfunction

    // settled look at pending and all four positions
    task automatic look(input logic [7:0] c, input logic [7:0] d, input logic p);
        @(posedge clk_in);
        @(negedge clk_in);
        chk({31'h0, trim_pending_out}, {31'h0, p}, "pending flag");
        for (int i = 0; i < 4; i++) begin
            chk({20'h0, pos[i]}, {20'h0, trimmed(nom[i], (i < 2) ? c : d, i % 2 == 0)}, "pos");
        end
    endtask

    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_in);
        fails++;
        $display("wrong value at %0t ns: run hung", $time);
        stop_test;
    end

    initial begin
        {clk_in, rst_b_in, psel_in, penable_in, pwrite_in, period_start_in} = 6'h00;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        pstrb_in = 4'h0;
        nom = '{12'h100, 12'h200, 12'h300, 12'h400};
        fails = 0;
        checks = 0;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        tc = 8'h00;
        td = 8'h00;
        rd(ADDR_C, 32'h0, 1'b0);
        rd(ADDR_D, 32'h0, 1'b0);
        look(tc, td, 1'b0);
        rd(ADDR_X, 32'h0, 1'b1);
        wr(ADDR_X, 32'hFF, 4'hF, 1'b1);
        for (int i = 0; i < 8; i++) begin
            nc = {i[0], i[2:0], ~i[0], ~i[2:0]};
            nd = {nc[3:0], nc[7:4]};
            wr(ADDR_C, {24'hA5A5A5, nc}, 4'hF, 1'b0);
            wr(ADDR_D, {24'h5A5A5A, nd}, 4'hF, 1'b0);
            look(tc, td, 1'b1);
            start_period;
            look(nc, nd, 1'b0);
            rd(ADDR_C, {24'h0, nc}, 1'b0);
            rd(ADDR_S, stat(nc, nd, 4'h0), 1'b0);
            tc = nc;
            td = nd;
        end
        // write without low byte lane ignored
        wr(ADDR_C, 32'h77, 4'hE, 1'b0);
        rd(ADDR_C, {24'h0, tc}, 1'b0);
        // shifts past zero and past the top saturate
        @(posedge clk_in);
        nom[0] <= 12'h003;
        nom[1] <= 12'hFFD;
        wr(ADDR_C, 32'hF7, 4'hF, 1'b0);
        start_period;
        look(8'hF7, td, 1'b0);
        rd(ADDR_S, stat(8'hF7, td, 4'h3), 1'b0);
        wr(ADDR_C, 32'h00, 4'hF, 1'b0);
        start_period;
        wr(ADDR_S, 32'h00F0_0000, 4'h4, 1'b0);
        rd(ADDR_S, stat(8'h00, td, 4'h0), 1'b0);
        stop_test;
    end
endmodule
